// File: hw/pcr_bank.sv
// command register bank for the two channel power manager
`timescale 1ns/10ps
`default_nettype none
module pcr_bank (
   input  wire logic             ref_clk_i,      // 20 MHz clock
   input  wire logic             sys_rst_i,      // synchronous reset, high
   input  wire pcr_pkg::pcr_req_t req_i,         // command from link target
   input  wire logic             page_i,         // active page
   input  wire logic [15:0]      iout_ua_i [2],  // per channel output current, microamps
   input  wire logic [15:0]      iin_i,          // input current sample
   input  wire logic [15:0]      pin_i,          // input power sample
   input  wire logic             sample_i,       // new input sample strobe
   input  wire logic [15:0]      energy_inc_i,   // energy per tick
   input  wire logic             energy_tick_i,  // accumulate strobe
   input  wire logic [1:0]       faulted_off_i,  // per channel faulted off, async
   output pcr_pkg::pcr_rsp_t     rsp_o,          // answer to link target
   output logic [15:0]           dac_code_o [2], // start-up dac codes
   output logic [1:0]            pg_gpo_o,       // power good pin data
   output logic                  fault_zero_o,   // drive fault line zero low
   output logic                  fault_one_o,    // drive fault line one low
   output logic                  ee_wr_o,        // eeprom word write pulse
   output logic [5:0]            ee_addr_o,      // eeprom word address
   output logic [15:0]           ee_wdata_o      // eeprom write word
);
   typedef struct packed {
      pcr_pkg::pcr_chan_t [1:0]          ch;
      logic [7:0]                        en_cfg;
      logic [15:0]                       tempco;
      logic [15:0]                       xh_cmd;
      logic [15:0]                       xh0;
      logic [15:0]                       xh1;
      logic [15:0]                       glb;
      logic                              unlocked;
      logic [pcr_pkg::EE_AW-1:0]         ee_ptr;
      logic [15:0]                       iin_max;
      logic [15:0]                       iin_min;
      logic [15:0]                       pin_max;
      logic [15:0]                       pin_min;
      logic [pcr_pkg::ENERGY_W-1:0]      energy;
      logic [pcr_pkg::ETIME_W-1:0]       etime;
      logic [1:0]                        flt_s1;
      logic [1:0]                        flt_s2;
      logic                              erasing;
      logic [pcr_pkg::EE_AW-1:0]         er_ptr;
      pcr_pkg::pcr_rsp_t                 rsp;
      logic [1:0]                        pg;
      logic                              f0;
      logic                              f1;
      logic                              ee_wr;
      logic [pcr_pkg::EE_AW-1:0]         ee_addr;
      logic [15:0]                       ee_wdata;
   } st_t;

   st_t st_r;
   st_t st_nxt;
   logic [15:0] ee_mem [pcr_pkg::EE_WORDS];
   logic [15:0] ee_rd;
   logic [15:0] iout_cnt [2];

   // output current as plain counts of 2.5 mA
   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_iout
         assign iout_cnt[g] = 16'(iout_ua_i[g] / pcr_pkg::IOUT_STEP_UA);
      end
   endgenerate

   // true where a write to this code is allowed
   function automatic logic writable(input logic [7:0] c);
      case (c)
         pcr_pkg::CMD_THETA, pcr_pkg::CMD_RSV2, pcr_pkg::CMD_UNLOCK, pcr_pkg::CMD_ERASE,
         pcr_pkg::CMD_EE_DATA, pcr_pkg::CMD_EN_CFG, pcr_pkg::CMD_TEMPCO,
         pcr_pkg::CMD_XH_CMD, pcr_pkg::CMD_XH0_DATA, pcr_pkg::CMD_XH1_DATA,
         pcr_pkg::CMD_PG_CFG, pcr_pkg::CMD_DAC_SU, pcr_pkg::CMD_PG_OUT,
         pcr_pkg::CMD_CH_CFG, pcr_pkg::CMD_GLB_CFG, pcr_pkg::CMD_FL0_PROP,
         pcr_pkg::CMD_FL1_PROP: writable = 1'b1;
         default: writable = 1'b0;
      endcase
   endfunction

   // eeprom array, read port follows the sequential pointer
   always_ff @(posedge ref_clk_i) begin
      if (st_r.ee_wr) begin
         ee_mem[st_r.ee_addr] <= st_r.ee_wdata;
      end
   end
   assign ee_rd = ee_mem[st_r.ee_ptr];

   // next state: command decode, trackers, fault propagation
   always_comb begin
      logic        wr;
      logic        rd;
      logic        p;
      logic [15:0] d;
      logic        ok;
      st_nxt = st_r;
      p  = page_i;
      wr = req_i.valid && (req_i.kind == pcr_pkg::PCR_WR_BYTE
                        || req_i.kind == pcr_pkg::PCR_WR_WORD);
      rd = req_i.valid && req_i.kind == pcr_pkg::PCR_READ;
      d  = 16'h0000;
      ok = 1'b1;
      st_nxt.rsp   = '0;
      st_nxt.ee_wr = 1'b0;

      // bulk erase walks the array one word per cycle
      if (st_r.erasing) begin
         st_nxt.ee_wr    = 1'b1;
         st_nxt.ee_addr  = st_r.er_ptr;
         st_nxt.ee_wdata = {pcr_pkg::ERASED_BYTE, pcr_pkg::ERASED_BYTE};
         st_nxt.er_ptr   = st_r.er_ptr + 1'b1;
         if (&st_r.er_ptr) begin
            st_nxt.erasing = 1'b0;
         end
      end

      // peak and minimum trackers
      if (sample_i) begin
         if (iin_i > st_r.iin_max) st_nxt.iin_max = iin_i;
         if (iin_i < st_r.iin_min) st_nxt.iin_min = iin_i;
         if (pin_i > st_r.pin_max) st_nxt.pin_max = pin_i;
         if (pin_i < st_r.pin_min) st_nxt.pin_min = pin_i;
      end

      // energy accumulates unless a clear lands in the same cycle
      if (energy_tick_i) begin
         st_nxt.energy = st_r.energy + pcr_pkg::ENERGY_W'(energy_inc_i);
         st_nxt.etime  = st_r.etime + 1'b1;
      end

      if (wr) begin
         ok = writable(req_i.code);
         case (req_i.code)
            pcr_pkg::CMD_THETA:    st_nxt.ch[p].theta = req_i.data;
            pcr_pkg::CMD_RSV2:     st_nxt.ch[p].rsv2 = req_i.data;
            pcr_pkg::CMD_UNLOCK:   st_nxt.unlocked =
                                      (req_i.data[7:0] == pcr_pkg::UNLOCK_KEY);
            pcr_pkg::CMD_ERASE: begin
               ok = st_r.unlocked && !st_r.erasing;
               if (ok) begin
                  st_nxt.erasing = 1'b1;
                  st_nxt.er_ptr  = '0;
                  st_nxt.ee_ptr  = '0;
               end
            end
            pcr_pkg::CMD_EE_DATA: begin
               ok = st_r.unlocked && !st_r.erasing;
               if (ok) begin
                  st_nxt.ee_wr    = 1'b1;
                  st_nxt.ee_addr  = st_r.ee_ptr;
                  st_nxt.ee_wdata = req_i.data;
                  st_nxt.ee_ptr   = st_r.ee_ptr + 1'b1;
               end
            end
            pcr_pkg::CMD_EN_CFG:   st_nxt.en_cfg = req_i.data[7:0];
            pcr_pkg::CMD_TEMPCO:   st_nxt.tempco = req_i.data;
            pcr_pkg::CMD_XH_CMD:   st_nxt.xh_cmd = req_i.data;
            pcr_pkg::CMD_XH0_DATA: st_nxt.xh0 = req_i.data;
            pcr_pkg::CMD_XH1_DATA: st_nxt.xh1 = req_i.data;
            pcr_pkg::CMD_PG_CFG:   st_nxt.ch[p].pg_cfg = req_i.data;
            pcr_pkg::CMD_DAC_SU:   st_nxt.ch[p].dac_su = req_i.data;
            pcr_pkg::CMD_PG_OUT:   st_nxt.ch[p].pg_out = req_i.data[7:0];
            pcr_pkg::CMD_CH_CFG:   st_nxt.ch[p].ch_cfg = req_i.data;
            pcr_pkg::CMD_GLB_CFG:  st_nxt.glb = req_i.data;
            pcr_pkg::CMD_FL0_PROP: st_nxt.ch[p].fl0_prop = req_i.data[7:0];
            pcr_pkg::CMD_FL1_PROP: st_nxt.ch[p].fl1_prop = req_i.data[7:0];
            default: ;
         endcase
         st_nxt.rsp.valid = 1'b1;
         st_nxt.rsp.ack   = ok;
      end else if (req_i.valid && req_i.kind == pcr_pkg::PCR_SEND) begin
         ok = (req_i.code == pcr_pkg::CMD_CLR_EN);
         if (ok) begin
            st_nxt.energy = '0;
            st_nxt.etime  = '0;
         end
         st_nxt.rsp.valid = 1'b1;
         st_nxt.rsp.ack   = ok;
      end else if (rd) begin
         st_nxt.rsp.count = 8'h02;
         case (req_i.code)
            pcr_pkg::CMD_THETA:    d = st_r.ch[p].theta;
            pcr_pkg::CMD_IOUT_FS:  d = iout_cnt[p];
            pcr_pkg::CMD_RSV2:     d = st_r.ch[p].rsv2;
            pcr_pkg::CMD_UNLOCK:   d = {15'h0000, st_r.unlocked};
            pcr_pkg::CMD_ERASE:    d = {15'h0000, st_r.erasing};
            pcr_pkg::CMD_EE_DATA: begin
               ok = st_r.unlocked && !st_r.erasing;
               if (ok) begin
                  d = ee_rd;
                  st_nxt.ee_ptr = st_r.ee_ptr + 1'b1;
               end
            end
            pcr_pkg::CMD_ENERGY: begin
               d = st_r.energy[15:0];
               st_nxt.rsp.count = pcr_pkg::ENERGY_LEN;
            end
            pcr_pkg::CMD_EN_CFG:   d = {8'h00, st_r.en_cfg};
            pcr_pkg::CMD_LOT:      d = {8'h00, pcr_pkg::LOT_CODE};
            pcr_pkg::CMD_TEMPCO:   d = st_r.tempco;
            pcr_pkg::CMD_IIN_MAX:  d = st_r.iin_max;
            pcr_pkg::CMD_IIN_MIN:  d = st_r.iin_min;
            pcr_pkg::CMD_PIN_MAX:  d = st_r.pin_max;
            pcr_pkg::CMD_PIN_MIN:  d = st_r.pin_min;
            pcr_pkg::CMD_XH_CMD:   d = st_r.xh_cmd;
            pcr_pkg::CMD_XH0_DATA: d = st_r.xh0;
            pcr_pkg::CMD_XH1_DATA: d = st_r.xh1;
            pcr_pkg::CMD_PG_CFG:   d = st_r.ch[p].pg_cfg;
            pcr_pkg::CMD_DAC_SU:   d = st_r.ch[p].dac_su;
            pcr_pkg::CMD_PG_OUT:   d = {8'h00, st_r.ch[p].pg_out};
            pcr_pkg::CMD_CH_CFG:   d = st_r.ch[p].ch_cfg;
            pcr_pkg::CMD_GLB_CFG:  d = st_r.glb;
            pcr_pkg::CMD_FL0_PROP: d = {8'h00, st_r.ch[p].fl0_prop};
            pcr_pkg::CMD_FL1_PROP: d = {8'h00, st_r.ch[p].fl1_prop};
            default:               ok = 1'b0;
         endcase
         st_nxt.rsp.valid = 1'b1;
         st_nxt.rsp.ack   = ok;
         st_nxt.rsp.data  = ok ? d : 16'h0000;
      end

      // fault inputs cross through two flops before use
      st_nxt.flt_s1 = faulted_off_i;
      st_nxt.flt_s2 = st_r.flt_s1;
      st_nxt.f0 = (st_r.flt_s2[0] && st_r.ch[0].fl0_prop[0])
               || (st_r.flt_s2[1] && st_r.ch[1].fl0_prop[0]);
      st_nxt.f1 = (st_r.flt_s2[0] && st_r.ch[0].fl1_prop[0])
               || (st_r.flt_s2[1] && st_r.ch[1].fl1_prop[0]);
      st_nxt.pg = {st_r.ch[1].pg_out[0], st_r.ch[0].pg_out[0]};
   end

   // reset values, then register the whole state
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         st_r <= '0;
         for (int i = 0; i < 2; i++) begin
            st_r.ch[i].theta  <= pcr_pkg::RST_THETA;
            st_r.ch[i].pg_cfg <= pcr_pkg::RST_PG_CFG;
            st_r.ch[i].ch_cfg <= pcr_pkg::RST_CH_CFG;
            st_r.ch[i].dac_su <= pcr_pkg::RST_ZERO16;
            st_r.ch[i].pg_out <= pcr_pkg::RST_ZERO8;
         end
         st_r.glb     <= pcr_pkg::RST_GLB_CFG;
         st_r.iin_min <= pcr_pkg::MIN_START;
         st_r.pin_min <= pcr_pkg::MIN_START;
      end else begin
         st_r <= st_nxt;
      end
   end

   // outputs straight from state flops
   assign rsp_o         = st_r.rsp;
   assign dac_code_o[0] = st_r.ch[0].dac_su;
   assign dac_code_o[1] = st_r.ch[1].dac_su;
   assign pg_gpo_o      = st_r.pg;
   assign fault_zero_o  = st_r.f0;
   assign fault_one_o   = st_r.f1;
   assign ee_wr_o       = st_r.ee_wr;
   assign ee_addr_o     = st_r.ee_addr;
   assign ee_wdata_o    = st_r.ee_wdata;
endmodule
`default_nettype wire

// File: hw/pcr_pkg.sv
// constants and carrier types for the power manager command register bank
// Summary of operation
// - read-only per-channel output current word, one count is 2.5 mA
// - erase and data port refused until the unlock byte is written
// - writing the erase byte initialises the user eeprom for bulk programming
// - data port moves one word per transaction, stepping sequentially
// - energy clear send byte zeroes accumulated energy and elapsed time
// - read-only peak and minimum input current and input power, tracked per sample
// - per channel fault line propagate bytes gate faulted-off onto fault lines
// - unpaged global configuration word, default 0x007b
// - extra host command word plus one data word per host, all default zero
// - per channel power good output data byte, default zero
// - per channel dac start-up code word, default zero, loaded at start-up
// - input energy returned only by block read, writes refused
// - unpaged energy measure configuration byte, default zero
// - input current gain temperature coefficient word, default zero
// - per channel inductor thermal resistance word, default 0x8000
// - per channel power good pin configuration word, default 0xc046
// - per channel paged channel configuration word, default 0x0080
package pcr_pkg;
   localparam logic [7:0] CMD_THETA    = 8'hba;
   localparam logic [7:0] CMD_IOUT_FS  = 8'hbb;
   localparam logic [7:0] CMD_RSV2     = 8'hbc;
   localparam logic [7:0] CMD_UNLOCK   = 8'hbd;
   localparam logic [7:0] CMD_ERASE    = 8'hbe;
   localparam logic [7:0] CMD_EE_DATA  = 8'hbf;
   localparam logic [7:0] CMD_ENERGY   = 8'hc0;
   localparam logic [7:0] CMD_EN_CFG   = 8'hc1;
   localparam logic [7:0] CMD_LOT      = 8'hc2;
   localparam logic [7:0] CMD_TEMPCO   = 8'hc3;
   localparam logic [7:0] CMD_IIN_MAX  = 8'hc4;
   localparam logic [7:0] CMD_IIN_MIN  = 8'hc5;
   localparam logic [7:0] CMD_PIN_MAX  = 8'hc6;
   localparam logic [7:0] CMD_PIN_MIN  = 8'hc7;
   localparam logic [7:0] CMD_XH_CMD   = 8'hc8;
   localparam logic [7:0] CMD_XH0_DATA = 8'hc9;
   localparam logic [7:0] CMD_XH1_DATA = 8'hca;
   localparam logic [7:0] CMD_PG_CFG   = 8'hcb;
   localparam logic [7:0] CMD_CLR_EN   = 8'hcc;
   localparam logic [7:0] CMD_DAC_SU   = 8'hcd;
   localparam logic [7:0] CMD_PG_OUT   = 8'hce;
   localparam logic [7:0] CMD_CH_CFG   = 8'hd0;
   localparam logic [7:0] CMD_GLB_CFG  = 8'hd1;
   localparam logic [7:0] CMD_FL0_PROP = 8'hd2;
   localparam logic [7:0] CMD_FL1_PROP = 8'hd3;

   localparam logic [15:0] RST_THETA   = 16'h8000;
   localparam logic [15:0] RST_PG_CFG  = 16'hc046;
   localparam logic [15:0] RST_CH_CFG  = 16'h0080;
   localparam logic [15:0] RST_GLB_CFG = 16'h007b;
   localparam logic [15:0] RST_ZERO16  = 16'h0000;
   localparam logic [7:0]  RST_ZERO8   = 8'h00;
   localparam logic [15:0] MIN_START   = 16'hffff;   // minimum trackers start high
   localparam logic [7:0]  UNLOCK_KEY  = 8'h2b;      // arbitrary unlock byte value
   localparam logic [7:0]  ERASED_BYTE = 8'hff;
   localparam logic [7:0]  LOT_CODE    = 8'h00;      // arbitrary lot code
   localparam logic [7:0]  ENERGY_LEN  = 8'h06;      // block byte count
   localparam int          EE_WORDS    = 64;
   localparam int          EE_AW       = 6;
   localparam int          ENERGY_W    = 24;
   localparam int          ETIME_W     = 24;
   localparam logic [15:0] IOUT_STEP_UA = 16'h09c4;  // one count in microamperes

   // command kinds on the target link
   typedef enum logic [3:0] {
      PCR_WR_BYTE = 4'b0001,
      PCR_WR_WORD = 4'b0010,
      PCR_SEND    = 4'b0100,
      PCR_READ    = 4'b1000
   } pcr_kind_t;

   typedef struct packed {
      logic        valid;
      pcr_kind_t   kind;
      logic [7:0]  code;
      logic [15:0] data;
   } pcr_req_t;

   typedef struct packed {
      logic        valid;
      logic        ack;      // 0 refused or unmapped
      logic [15:0] data;
      logic [7:0]  count;    // bytes in answer, block reads carry more
   } pcr_rsp_t;

   typedef struct packed {
      logic [15:0] theta;
      logic [15:0] rsv2;
      logic [15:0] pg_cfg;
      logic [15:0] dac_su;
      logic [7:0]  pg_out;
      logic [15:0] ch_cfg;
      logic [7:0]  fl0_prop;
      logic [7:0]  fl1_prop;
   } pcr_chan_t;
endpackage

// File: tb/pcr_checker.sv
// concurrent checks on the ports of the command register bank
`timescale 1ns/10ps
`default_nettype none
module pcr_checker (
   input wire logic              ref_clk_i,     // 20 MHz clock
   input wire logic              sys_rst_i,     // synchronous reset, high
   input wire pcr_pkg::pcr_req_t req_i,         // command from link target
   input wire logic [1:0]        faulted_off_i, // per channel faulted off
   input wire pcr_pkg::pcr_rsp_t rsp_o,         // answer to link target
   input wire logic              fault_zero_o,  // fault line zero drive
   input wire logic              ee_wr_o,       // eeprom write pulse
   input wire logic [5:0]        ee_addr_o      // eeprom word address
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (sys_rst_i);
   logic wr_q;
   logic rd_q;
   // request decode shared by the properties below
   assign wr_q = req_i.valid && (req_i.kind == pcr_pkg::PCR_WR_WORD ||
                                 req_i.kind == pcr_pkg::PCR_WR_BYTE);
   assign rd_q = req_i.valid && req_i.kind == pcr_pkg::PCR_READ;

   a_rsp_follows_req: assert property (req_i.valid |=> rsp_o.valid)
      else $error("no answer one cycle after a request");
   a_rsp_has_cause: assert property (rsp_o.valid |-> $past(req_i.valid))
      else $error("answer without a request");
   a_ro_write_refused: assert property (wr_q && req_i.code inside
      {8'hbb, 8'hc0, 8'hc2, 8'hc4, 8'hc5, 8'hc6, 8'hc7} |=> !rsp_o.ack)
      else $error("write to read-only command acknowledged");
   a_rw_write_acked: assert property (wr_q && req_i.code inside
      {8'hba, 8'hc1, 8'hc3, 8'hc8, 8'hcb, 8'hcd, 8'hd0, 8'hd1, 8'hd2} |=> rsp_o.ack)
      else $error("write to configuration refused");
   a_energy_block_len: assert property (rd_q && req_i.code == pcr_pkg::CMD_ENERGY
      |=> rsp_o.ack && rsp_o.count == pcr_pkg::ENERGY_LEN)
      else $error("energy block read has wrong count");
   a_send_other_refused: assert property (req_i.valid &&
      req_i.kind == pcr_pkg::PCR_SEND && req_i.code != pcr_pkg::CMD_CLR_EN |=> !rsp_o.ack)
      else $error("unknown send byte acknowledged");
   a_unmapped_read_zero: assert property (rd_q && req_i.code == 8'hcf
      |=> !rsp_o.ack && rsp_o.data == 16'h0000)
      else $error("unmapped read not refused");
   a_fault_has_cause: assert property (fault_zero_o |-> $past(faulted_off_i, 3) != 2'b00)
      else $error("fault line zero driven without a faulted channel");
   a_ee_addr_step: assert property (ee_wr_o && $past(ee_wr_o)
      |-> ee_addr_o == $past(ee_addr_o) + 6'h01)
      else $error("eeprom address did not step");

   c_erase_burst: cover property (ee_wr_o [*3]);
   c_fault_driven: cover property (fault_zero_o);
   c_energy_read: cover property (rd_q && req_i.code == pcr_pkg::CMD_ENERGY);
endmodule
bind pcr_bank pcr_checker chk_u (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .req_i(req_i),
   .faulted_off_i(faulted_off_i), .rsp_o(rsp_o), .fault_zero_o(fault_zero_o),
   .ee_wr_o(ee_wr_o), .ee_addr_o(ee_addr_o));
`default_nettype wire

// File: tb/pcr_host.sv
// host controller model issuing commands to the register bank
`timescale 1ns/10ps
`default_nettype none
module pcr_host (
   input  wire logic              ref_clk_i, // 20 MHz clock
   output var pcr_pkg::pcr_req_t  req_o,     // command toward the bank
   output var logic               page_o,    // active page
   input  wire pcr_pkg::pcr_rsp_t rsp_i      // answer from the bank
);
   initial begin
      req_o = '0;
      page_o = 1'b0;
   end
   // one command per call; answer waited for a bounded number of cycles
   task automatic xfer(input pcr_pkg::pcr_kind_t k, input logic [7:0] c, input logic pg,
                       input logic [15:0] d, output pcr_pkg::pcr_rsp_t r);
      int n;
      n = 0;
      @(negedge ref_clk_i);
      req_o <= '{1'b1, k, c, d};
      page_o <= pg;
      @(negedge ref_clk_i);
      req_o.valid <= 1'b0;
      req_o.data <= ~d; // released data no longer shows the old word
      while (rsp_i.valid !== 1'b1 && n < 4) begin
         @(negedge ref_clk_i);
         n++;
      end
      r = rsp_i;
   endtask
endmodule
`default_nettype wire

// File: tb/tb.sv
// self-checking bench for the power manager command register bank
`timescale 1ns/10ps
`default_nettype none
module tb;
   logic              ref_clk_i, sys_rst_i, sample_i, energy_tick_i, page, erasing;
   logic [1:0]        faulted_off_i, pg_gpo;
   logic [15:0]       iin_i, pin_i, energy_inc_i, ee_wdata;
   logic [15:0]       iout_ua_i [2];
   logic [15:0]       dac_code [2];
   logic              f0, f1, ee_wr;
   logic [5:0]        ee_addr;
   pcr_pkg::pcr_req_t req;
   pcr_pkg::pcr_rsp_t rsp, r;
   int                num_errors = 0;
   int                checks = 0;
   int                ee_cnt = 0;

   pcr_bank dut_u (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .req_i(req), .page_i(page),
      .iout_ua_i(iout_ua_i), .iin_i(iin_i), .pin_i(pin_i), .sample_i(sample_i),
      .energy_inc_i(energy_inc_i), .energy_tick_i(energy_tick_i),
      .faulted_off_i(faulted_off_i), .rsp_o(rsp), .dac_code_o(dac_code), .pg_gpo_o(pg_gpo),
      .fault_zero_o(f0), .fault_one_o(f1), .ee_wr_o(ee_wr), .ee_addr_o(ee_addr),
      .ee_wdata_o(ee_wdata));
   pcr_host host_u (.ref_clk_i(ref_clk_i), .req_o(req), .page_o(page), .rsp_i(rsp));

   initial begin
      ref_clk_i = 1'b0;
      forever #25 ref_clk_i = ~ref_clk_i;
   end
   // tally eeprom writes at the falling edge, where the pulse is settled
   always @(negedge ref_clk_i) begin
      if (ee_wr === 1'b1) begin
         ee_cnt <= ee_cnt + 1;
         if (erasing) chk16("erase word", 16'hffff, ee_wdata);
      end
   end

   task automatic chk16(input string nm, input logic [15:0] exp, input logic [15:0] got);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic chk1(input string nm, input logic exp, input logic got);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch %s expected %b seen %b", nm, exp, got);
      end
   endtask
   task automatic cmd(input pcr_pkg::pcr_kind_t k, input logic [7:0] c, input logic pg,
                      input logic [15:0] d, input logic ack);
      host_u.xfer(k, c, pg, d, r);
      chk1("answer valid", 1'b1, r.valid);
      chk1("answer ack", ack, r.ack);
   endtask
   task automatic rd(input logic [7:0] c, input logic pg, input logic [15:0] exp);
      cmd(pcr_pkg::PCR_READ, c, pg, 16'h0000, 1'b1);
      chk16("read data", exp, r.data);
   endtask
   task automatic final_report;
      if (num_errors == 0 && checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // every readable setting except CMD_RSV2 comes up at its default on both pages
   task automatic t_defaults;
      logic [7:0]  dc [13] = '{8'hba, 8'hcb, 8'hd0, 8'hd1, 8'hc1, 8'hc3, 8'hc8, 8'hc9,
                               8'hca, 8'hcd, 8'hce, 8'hd2, 8'hd3};
      logic [15:0] dv [4] = '{16'h8000, 16'hc046, 16'h0080, 16'h007b};
      for (int p = 0; p < 2; p++) begin
         for (int i = 0; i < 13; i++) begin
            rd(dc[i], p[0], (i < 4) ? dv[i] : 16'h0000);
         end
      end
   endtask
   // paged words keep one copy per channel, unpaged ones a single copy
   task automatic t_paged;
      logic [7:0] pc [4] = '{8'hba, 8'hcb, 8'hcd, 8'hd0};
      for (int i = 0; i < 4; i++) begin
         cmd(pcr_pkg::PCR_WR_WORD, pc[i], 1'b0, 16'h1100 + 16'(i), 1'b1);
         cmd(pcr_pkg::PCR_WR_WORD, pc[i], 1'b1, 16'h2200 + 16'(i), 1'b1);
      end
      for (int i = 0; i < 4; i++) begin
         rd(pc[i], 1'b0, 16'h1100 + 16'(i));
         rd(pc[i], 1'b1, 16'h2200 + 16'(i));
      end
      chk16("dac code zero", 16'h1102, dac_code[0]);
      chk16("dac code one", 16'h2202, dac_code[1]);
      cmd(pcr_pkg::PCR_WR_WORD, 8'hd1, 1'b0, 16'h0a5a, 1'b1);
      rd(8'hd1, 1'b1, 16'h0a5a);
      cmd(pcr_pkg::PCR_WR_WORD, 8'hca, 1'b0, 16'h1234, 1'b1);
      rd(8'hca, 1'b1, 16'h1234);
      cmd(pcr_pkg::PCR_WR_BYTE, 8'hce, 1'b1, 16'h0001, 1'b1);
      rd(8'hce, 1'b1, 16'h0001);
      chk16("good pin outputs", 16'h0002, {14'h0000, pg_gpo});
   endtask
   // read-only commands refuse writes, an unmapped read is refused, and values are kept
   task automatic t_readonly;
      iout_ua_i[0] = 16'h61a8;
      iout_ua_i[1] = 16'h30d3;
      repeat (3) @(negedge ref_clk_i);
      rd(8'hbb, 1'b0, 16'h000a);
      rd(8'hbb, 1'b1, 16'h0004);
      cmd(pcr_pkg::PCR_WR_WORD, 8'hbb, 1'b0, 16'h5555, 1'b0);
      cmd(pcr_pkg::PCR_WR_WORD, 8'hc0, 1'b0, 16'h5555, 1'b0);
      cmd(pcr_pkg::PCR_WR_WORD, 8'hc4, 1'b0, 16'h5555, 1'b0);
      cmd(pcr_pkg::PCR_SEND, 8'hcb, 1'b0, 16'h0000, 1'b0);
      cmd(pcr_pkg::PCR_READ, 8'hcf, 1'b0, 16'h0000, 1'b0);
      rd(8'hbb, 1'b0, 16'h000a);
      rd(8'hcb, 1'b0, 16'h1101);
   endtask
   // peak and minimum trackers over three samples
   task automatic t_minmax;
      logic [15:0] s [3] = '{16'h0064, 16'h012c, 16'h00c8};
      for (int i = 0; i < 3; i++) begin
         @(negedge ref_clk_i);
         iin_i = s[i];
         pin_i = s[i] + 16'h0007;
         sample_i = 1'b1;
         @(negedge ref_clk_i);
         sample_i = 1'b0;
      end
      rd(8'hc4, 1'b0, 16'h012c);
      rd(8'hc5, 1'b0, 16'h0064);
      rd(8'hc6, 1'b0, 16'h0133);
      rd(8'hc7, 1'b0, 16'h006b);
   endtask
   // energy accumulates per tick, is read as a block and cleared by send byte
   task automatic t_energy;
      energy_inc_i = 16'h0010;
      repeat (3) begin
         @(negedge ref_clk_i);
         energy_tick_i = 1'b1;
         @(negedge ref_clk_i);
         energy_tick_i = 1'b0;
      end
      rd(8'hc0, 1'b0, 16'h0030);
      chk16("energy byte count", 16'h0006, {8'h00, r.count});
      cmd(pcr_pkg::PCR_SEND, 8'hcc, 1'b0, 16'h0000, 1'b1);
      rd(8'hc0, 1'b0, 16'h0000);
   endtask
   // locked eeprom refuses, unlock then erase, then sequential data words
   task automatic t_eeprom;
      cmd(pcr_pkg::PCR_WR_BYTE, 8'hbe, 1'b0, 16'h0000, 1'b0);
      cmd(pcr_pkg::PCR_WR_WORD, 8'hbf, 1'b0, 16'h1234, 1'b0);
      chk16("locked writes", 16'h0000, 16'(ee_cnt));
      cmd(pcr_pkg::PCR_WR_BYTE, 8'hbd, 1'b0, {8'h00, pcr_pkg::UNLOCK_KEY}, 1'b1);
      erasing = 1'b1;
      cmd(pcr_pkg::PCR_WR_BYTE, 8'hbe, 1'b0, 16'h0000, 1'b1);
      cmd(pcr_pkg::PCR_WR_WORD, 8'hbf, 1'b0, 16'h0000, 1'b0);
      repeat (80) @(negedge ref_clk_i);
      erasing = 1'b0;
      chk16("erase word count", 16'h0040, 16'(ee_cnt));
      for (int i = 0; i < 2; i++) begin
         cmd(pcr_pkg::PCR_WR_WORD, 8'hbf, 1'b0, 16'ha0a0 + 16'(i), 1'b1);
         @(negedge ref_clk_i);
         chk16("data port word", 16'ha0a0 + 16'(i), ee_wdata);
         chk16("data port address", 16'(i), {10'h000, ee_addr});
         chk16("data port writes", 16'h0041 + 16'(i), 16'(ee_cnt));
      end
      rd(8'hbf, 1'b0, 16'hffff);
   endtask
   // propagate bytes are per channel and gate each fault line separately
   task automatic t_fault;
      cmd(pcr_pkg::PCR_WR_BYTE, 8'hd2, 1'b0, 16'h0001, 1'b1);
      cmd(pcr_pkg::PCR_WR_BYTE, 8'hd3, 1'b1, 16'h0001, 1'b1);
      faulted_off_i = 2'b01;
      repeat (4) @(negedge ref_clk_i);
      chk1("fault line zero", 1'b1, f0);
      chk1("fault line one", 1'b0, f1);
      faulted_off_i = 2'b10;
      repeat (4) @(negedge ref_clk_i);
      chk1("fault line zero", 1'b0, f0);
      chk1("fault line one", 1'b1, f1);
      faulted_off_i = 2'b00;
   endtask
   // a second reset in mid-run brings the settings back to their defaults
   task automatic t_reset;
      @(negedge ref_clk_i);
      sys_rst_i = 1'b1;
      @(negedge ref_clk_i);
      sys_rst_i = 1'b0;
      chk16("dac code after reset", 16'h0000, dac_code[1]);
      rd(8'hba, 1'b1, 16'h8000);
      rd(8'hd1, 1'b0, 16'h007b);
   endtask

   // main sequence: reset, then every scenario in turn
   initial begin
      sys_rst_i = 1'b1;
      sample_i = 1'b0;
      energy_tick_i = 1'b0;
      erasing = 1'b0;
      faulted_off_i = 2'b00;
      iin_i = 16'h0000;
      pin_i = 16'h0000;
      energy_inc_i = 16'h0000;
      iout_ua_i[0] = 16'h0000;
      iout_ua_i[1] = 16'h0000;
      repeat (5) @(negedge ref_clk_i);
      sys_rst_i = 1'b0;
      t_defaults();
      t_paged();
      t_readonly();
      t_minmax();
      t_energy();
      t_eeprom();
      t_fault();
      t_reset();
      final_report();
   end
   // a hang is cut short and counted
   initial begin
      repeat (20000) @(posedge ref_clk_i);
      num_errors++;
      final_report();
   end
endmodule
`default_nettype wire
